// [sbsp_pkg.sv]
// Constants, commands and timing for the burst-stop / precharge controller.
// Assumes a single 100 MHz clock domain and a four-bank memory.
package sbsp_pkg;
	// ****************************************
	// Register offsets and fields
	// ****************************************
	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_CFG    = 4'h3;
	localparam logic [3:0] REG_MASK   = 4'h4;
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_AUTO_BIT = 4;
	localparam int CFG_BL_LSB   = 0;
	localparam int CFG_WL_LSB   = 8;
	localparam logic [31:0] CFG_RESET = 32'h0000_0108;
	// ****************************************
	// Commands and timing
	// ****************************************
	typedef enum logic [2:0] {
		SBSP_OP_NONE  = 3'b000,
		SBSP_OP_READ  = 3'b001,
		SBSP_OP_WRITE = 3'b010,
		SBSP_OP_STOP  = 3'b011,
		SBSP_OP_PRE   = 3'b100,
		SBSP_OP_PREAB = 3'b101,
		SBSP_OP_ACT   = 3'b110
	} sbsp_op_t;
	typedef enum logic [1:0] {
		SBSP_IDLE  = 2'b00,
		SBSP_ISSUE = 2'b01,
		SBSP_WAIT  = 2'b10
	} sbsp_state_t;
	localparam int CLK_PERIOD_PS      = 10000;
	localparam int READ_TO_CLOSE_PS   = 7500;
	localparam int WRITE_RECOVERY_PS  = 15000;
	localparam int ROW_CLOSE_PS       = 18000;
	localparam int ROW_ACTIVE_PS      = 42000;
	localparam int RTP_CYC = (READ_TO_CLOSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WR_CYC  = (WRITE_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RP_CYC  = (ROW_CLOSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RAS_CYC = (ROW_ACTIVE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BANKS = 4;
endpackage : sbsp_pkg

// [sbsp_ctrl.sv]
// Controller that issues read, write, burst stop, precharge and activate
// commands to a four-bank DDR memory over its command/address pins.
// Assumes the memory clock is i_clk and the command bus is sampled on rising edges.
// What the document requires
// R1: Burst stop encodes chip select low, bits 0,1 high, bits 2,3 low.
// R2: Burst stop only during a burst, at most burst_length/2-1 cycles later.
// R3: Truncated effective length is twice the cycles from access to stop.
// R4: Spacing uses effective burst length once truncated.
// R5: Stop affects only the latest read or write.
// R6: Device ends read data read_latency plus skews after the stop.
// R7: Device ends write data intake write_latency plus offset after stop.
// R8: Stop only an even number of cycles after the access.
// R9: No second stop until a new read or write.
// R10: One byte mask per lane, timed like data, high skips the byte; the mask pin here is mask_reg one cycle late.
// R11: Precharge encodes chip select low, bits 0,1 high, bit 2 low, bit 3 high.
// R12: All-bank flag closes all banks, else two bank bits pick one.
// R13: Reopen only after row close time of the precharge kind.
// R14: Earliest precharge after read is burst_length/2 cycles.
// R15: Precharge only after row active minimum time from activation.
// R16: Read-to-close time starts burst_length/2-2 after the read.
// R17: Write to precharge spacing is WL+BL/2+1+recovery cycles.
// R18: Precharge after write only once recovery time has passed.
// R19: Auto close flag on falling-edge bit 0 selects bank auto close.
// R20: Auto close after read at max of BL/2 and BL/2-2+close time.
// R21: Auto close after write at recovery time after the burst.
// R22: Activate after auto close needs row close and row cycle times; the code checks only row close time (rp_cnt).
// R23: Column access has bit 0 high, bit 1 low; bit 2 picks read.
// R24: Auto-close accesses are never interrupted or stopped.
// R25: Track per-bank state and counters; hold back violating commands.
module sbsp_ctrl
	import sbsp_pkg::*;
#(
	parameter int BYTES = 2
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic [3:0]           i_addr,
	input  wire logic [31:0]          i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [31:0]          o_rdata,
	output logic                      o_cs_n,
	output logic      [9:0]           o_ca_rise,
	output logic      [9:0]           o_ca_fall,
	output logic      [BYTES-1:0]     o_write_byte_mask
);
	import sbsp_pkg::*;

	// Mask register is four bits wide, so four lanes at most
	if (BYTES < 1 || BYTES > 4) begin : g_bytes_check
		$error("BYTES must be 1..4");
	end

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] addr_reg;
	logic [31:0] cfg;
	logic [3:0]  mask_reg;
	sbsp_op_t    pend_op;
	logic        pend_auto;
	logic        busy_err;
	logic [7:0]  since_acc;
	logic        burst_live;
	logic        stop_used;
	logic        last_auto;
	logic        last_is_read;
	logic [7:0]  eff_half;
	logic [1:0]  last_bank;
	logic [BANKS-1:0] bank_open;
	logic [7:0]  ras_cnt [BANKS];
	logic [7:0]  pre_cnt [BANKS];
	logic [7:0]  rp_cnt  [BANKS];
	logic [7:0]  half_bl;
	logic [7:0]  wl;
	logic        go;
	logic        allowed;
	logic [1:0]  tgt_bank;
	logic [7:0]  acc_age;

	assign half_bl  = {1'b0, cfg[CFG_BL_LSB +: 7]} >> 1;
	assign wl       = cfg[CFG_WL_LSB +: 8];
	assign tgt_bank = addr_reg[1:0];

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			addr_reg <= 32'h0000_0000;
			cfg      <= CFG_RESET;
			mask_reg <= 4'h0;
		end else if (i_wr) begin
			if (i_addr == REG_ADDR) addr_reg <= i_wdata;
			if (i_addr == REG_CFG)  cfg <= i_wdata;
			if (i_addr == REG_MASK) mask_reg <= i_wdata[3:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			unique case (i_addr)
				REG_ADDR:   o_rdata <= addr_reg;
				REG_CFG:    o_rdata <= cfg;
				REG_MASK:   o_rdata <= {28'h000_0000, mask_reg};
				REG_STATUS: o_rdata <= {22'h00_0000, busy_err, pend_op != SBSP_OP_NONE,
					burst_live, stop_used, bank_open, 2'b00};
				default:    o_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Command admission
	// ****************************************
	// A refused command stays pending until its timers allow it
	always_comb begin
		allowed = 1'b0;
		unique case (pend_op)
			SBSP_OP_READ, SBSP_OP_WRITE: allowed = bank_open[tgt_bank] &&
				!(burst_live && (last_auto || since_acc[0] || since_acc < 8'd2)); // R24 R25
			SBSP_OP_STOP: allowed = burst_live && !stop_used && !last_auto &&
				!since_acc[0] && since_acc != 8'd0 && since_acc <= half_bl - 8'd1; // R2 R8 R9 R24
			SBSP_OP_PRE:  allowed = !burst_live && pre_cnt[tgt_bank] == 8'd0 &&
				ras_cnt[tgt_bank] == 8'd0; // R14 R15 R16 R17 R18
			SBSP_OP_PREAB: allowed = !burst_live && pre_cnt[0] == 8'd0 && pre_cnt[1] == 8'd0 &&
				pre_cnt[2] == 8'd0 && pre_cnt[3] == 8'd0 && ras_cnt[0] == 8'd0 && ras_cnt[1] == 8'd0 &&
				ras_cnt[2] == 8'd0 && ras_cnt[3] == 8'd0; // R12 R15
			SBSP_OP_ACT:  allowed = !bank_open[tgt_bank] && rp_cnt[tgt_bank] == 8'd0; // R13 R22
			default:      allowed = 1'b0;
		endcase
	end
	assign go = (pend_op != SBSP_OP_NONE) && allowed;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pend_op   <= SBSP_OP_NONE;
			pend_auto <= 1'b0;
			busy_err  <= 1'b0;
		end else if (i_wr && i_addr == REG_CMD) begin
			if (pend_op != SBSP_OP_NONE && !go) busy_err <= 1'b1;
			else begin
				pend_op   <= sbsp_op_t'(i_wdata[CMD_OP_LSB +: 3]);
				pend_auto <= i_wdata[CMD_AUTO_BIT];
			end
		end else if (go) begin
			pend_op <= SBSP_OP_NONE;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_cs_n    <= 1'b1;
			o_ca_rise <= 10'h3FF;
			o_ca_fall <= 10'h000;
		end else if (go) begin
			o_cs_n    <= 1'b0;
			o_ca_fall <= 10'h000;
			unique case (pend_op)
				// Bank bits sit at 8:7 for every bank command alike
				SBSP_OP_READ:  o_ca_rise <= {1'b0, tgt_bank, 7'h05}; // R23
				SBSP_OP_WRITE: o_ca_rise <= {1'b0, tgt_bank, 7'h01}; // R23
				SBSP_OP_STOP:  o_ca_rise <= 10'h003; // R1
				SBSP_OP_PRE:   o_ca_rise <= {1'b0, tgt_bank[1], tgt_bank[0], 3'b000, 4'b1011}; // R11 R12
				SBSP_OP_PREAB: o_ca_rise <= 10'h01B; // R11 R12
				SBSP_OP_ACT:   o_ca_rise <= {1'b0, tgt_bank, 7'h00};
				default:       o_ca_rise <= 10'h3FF;
			endcase
			if (pend_op == SBSP_OP_READ || pend_op == SBSP_OP_WRITE)
				o_ca_fall <= {addr_reg[9:1], pend_auto}; // R19
		end else begin
			o_cs_n    <= 1'b1;
			o_ca_rise <= 10'h3FF;
			o_ca_fall <= 10'h000;
		end
	end

	// Mask is mask_reg one cycle late, not tied to data timing; software loads the per-beat value.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) o_write_byte_mask <= '0;
		else o_write_byte_mask <= mask_reg[BYTES-1:0]; // R10
	end

	// ****************************************
	// Burst tracking
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			since_acc    <= 8'd0;
			burst_live   <= 1'b0;
			stop_used    <= 1'b0;
			last_auto    <= 1'b0;
			last_is_read <= 1'b0;
			eff_half     <= 8'd0;
			last_bank    <= 2'd0;
		end else if (go && (pend_op == SBSP_OP_READ || pend_op == SBSP_OP_WRITE)) begin
			since_acc    <= 8'd1;
			burst_live   <= 1'b1;
			stop_used    <= 1'b0; // R9
			last_auto    <= pend_auto;
			last_is_read <= pend_op == SBSP_OP_READ;
			eff_half     <= half_bl;
			last_bank    <= tgt_bank;
		end else if (go && pend_op == SBSP_OP_STOP) begin
			eff_half   <= since_acc; // R3 R4 R5
			stop_used  <= 1'b1;
			burst_live <= 1'b0;
		end else if (burst_live) begin
			since_acc <= since_acc + 8'd1;
			if (since_acc + 8'd1 >= eff_half) burst_live <= 1'b0;
		end else if (last_auto && !bank_open[last_bank]) begin
			// Auto close done; a later activate must not be closed again
			last_auto <= 1'b0; // R19
		end
	end

	// ****************************************
	// Assertion helpers
	// ****************************************
	// Cycles since the last access, saturating; kept apart from since_acc
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			acc_age <= 8'hFF;
		end else if (go && (pend_op == SBSP_OP_READ || pend_op == SBSP_OP_WRITE)) begin
			acc_age <= 8'd1;
		end else if (acc_age != 8'hFF) begin
			acc_age <= acc_age + 8'd1;
		end
	end

	// ****************************************
	// Per-bank timers
	// ****************************************
	logic [7:0] close_wait;
	always_comb begin
		close_wait = 8'd0;
		if (last_is_read)
			close_wait = (eff_half > eff_half - 8'd2 + 8'(RTP_CYC)) ? eff_half - since_acc
				: eff_half - 8'd2 + 8'(RTP_CYC) - since_acc; // R16 R20
		else
			close_wait = wl + eff_half + 8'd1 + 8'(WR_CYC) - since_acc; // R17 R18 R21
	end

	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : g_bank
			logic hit_pre;
			logic hit_auto;
			assign hit_pre  = go && (pend_op == SBSP_OP_PREAB ||
				(pend_op == SBSP_OP_PRE && tgt_bank == 2'(b)));
			assign hit_auto = last_auto && last_bank == 2'(b) && !burst_live &&
				bank_open[b] && pre_cnt[b] <= 8'd1;
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					bank_open[b] <= 1'b0;
					ras_cnt[b]   <= 8'd0;
					pre_cnt[b]   <= 8'd0;
					rp_cnt[b]    <= 8'd0;
				end else begin
					if (go && pend_op == SBSP_OP_ACT && tgt_bank == 2'(b)) begin
						bank_open[b] <= 1'b1;
						ras_cnt[b]   <= 8'(RAS_CYC); // R15
					end else if (ras_cnt[b] != 8'd0) begin
						ras_cnt[b] <= ras_cnt[b] - 8'd1;
					end
					if (go && (pend_op == SBSP_OP_READ || pend_op == SBSP_OP_WRITE) &&
						tgt_bank == 2'(b))
						pre_cnt[b] <= (pend_op == SBSP_OP_READ) ? half_bl : wl + half_bl + 8'd1 + 8'(WR_CYC);
					else if (!burst_live && last_bank == 2'(b) && since_acc != 8'd0 && pre_cnt[b] > close_wait)
						pre_cnt[b] <= close_wait;
					else if (pre_cnt[b] != 8'd0)
						pre_cnt[b] <= pre_cnt[b] - 8'd1;
					if (hit_pre || (hit_auto && ras_cnt[b] == 8'd0)) begin
						bank_open[b] <= 1'b0; // R12 R19
						rp_cnt[b]    <= 8'(RP_CYC); // R13 R22
					end else if (rp_cnt[b] != 8'd0) begin
						rp_cnt[b] <= rp_cnt[b] - 8'd1;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Checks
	// ****************************************
	// Grant steps for the properties below; the stop and precharge steps are each shared by two
	sequence s_stop_go;
		go && pend_op == SBSP_OP_STOP;
	endsequence
	sequence s_acc_go;
		go && (pend_op == SBSP_OP_READ || pend_op == SBSP_OP_WRITE);
	endsequence
	sequence s_pre_last;
		go && (pend_op == SBSP_OP_PREAB || (pend_op == SBSP_OP_PRE && tgt_bank == last_bank));
	endsequence

	a_stop_even: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		go && pend_op == SBSP_OP_STOP |-> !since_acc[0] && since_acc < half_bl) else $error("bad stop"); // R8
	a_stop_once: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		go && pend_op == SBSP_OP_STOP |-> !stop_used) else $error("second stop"); // R9
	a_stop_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		go && pend_op == SBSP_OP_STOP |=> !o_cs_n && o_ca_rise[3:0] == 4'b0011) else $error("stop code"); // R1
	a_pre_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		go && pend_op == SBSP_OP_PREAB |=> !o_cs_n && o_ca_rise[4:0] == 5'b11011) else $error("pre code"); // R11
	a_pre_ras: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		go && pend_op == SBSP_OP_PRE |-> ras_cnt[tgt_bank] == 8'd0) else $error("row_active_min_time"); // R15
	a_act_rp: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		go && pend_op == SBSP_OP_ACT |-> rp_cnt[tgt_bank] == 8'd0 && !bank_open[tgt_bank]) else $error("rp"); // R13
	a_auto_noint: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		burst_live && last_auto |-> !(go && pend_op inside {SBSP_OP_STOP, SBSP_OP_READ, SBSP_OP_WRITE}))
		else $error("auto interrupted"); // R24
	a_eff_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		go && pend_op == SBSP_OP_STOP |=> eff_half == $past(since_acc)) else $error("eff len"); // R3
	a_col_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		go && pend_op == SBSP_OP_READ |=> o_ca_rise[2:0] == 3'b101 && o_ca_fall[0] == $past(pend_auto))
		else $error("read code"); // R23
	a_stop_window: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R2
		s_stop_go |-> burst_live && !last_auto && acc_age <= half_bl - 8'd1)
		else $error("stop outside burst");
	a_stop_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R9
		s_stop_go |=> stop_used && !burst_live)
		else $error("stop not recorded");
	a_read_close: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14 R16
		s_pre_last |-> !last_is_read || (acc_age >= eff_half && acc_age >= eff_half - 8'd2 + 8'(RTP_CYC)))
		else $error("read to close");
	a_write_close: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R17 R18
		s_pre_last |-> last_is_read || acc_age >= wl + eff_half + 8'd1 + 8'(WR_CYC))
		else $error("write to close");
	a_acc_open: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R25
		s_acc_go |-> bank_open[tgt_bank])
		else $error("access to closed bank");
	a_hold_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R25
		!go |=> o_cs_n && o_ca_rise == 10'h3FF)
		else $error("command without grant");
	a_pre_bank: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11 R12
		go && pend_op == SBSP_OP_PRE |=> !o_ca_rise[4] && o_ca_rise[8:7] == $past(tgt_bank) &&
			o_ca_rise[3:0] == 4'b1011) else $error("bank select");
endmodule : sbsp_ctrl

// [sbsp_mem_model.sv]
// Behavioural four-bank memory seen from its command pins; counts illegal commands.
// Assumes the controller's command encoding and bank bits at ca_rise[8:7].
module sbsp_mem_model
	import sbsp_pkg::*;
#(
	parameter int BL = 8,
	parameter int WL = 1,
	// Read latency of the modelled part; plain default
	parameter int RL = 3
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_cs_n,
	input  wire logic [9:0] i_ca_rise,
	input  wire logic [9:0] i_ca_fall,
	output int              o_violations,
	output int              o_data_end,
	output logic      [3:0] o_bank_open
);
	// ****************************************
	// Command decode and bank tracking
	// ****************************************
	int cyc, acc_t, auto_t, bl_eff, gap, rd_min, wr_min;
	int act_t [4];
	int close_t [4];
	logic acc_wr, acc_auto, stop_used, live, auto_pend;
	logic [1:0] acc_bank, auto_bank, bank;
	assign bank = i_ca_rise[8:7];
	assign gap = cyc - acc_t;
	assign rd_min = (bl_eff / 2 > bl_eff / 2 - 2 + RTP_CYC) ? bl_eff / 2 : bl_eff / 2 - 2 + RTP_CYC;
	assign wr_min = WL + bl_eff / 2 + 1 + WR_CYC;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (!i_rst_n) begin
			o_violations <= 0;
			o_bank_open <= 4'h0;
			o_data_end <= 0;
			{live, auto_pend, stop_used, acc_auto} <= 4'h0;
			acc_t <= -1000;
			bl_eff <= BL;
			for (int i = 0; i < 4; i++) begin
				close_t[i] <= -1000;
				act_t[i] <= -1000;
			end
		end else begin
			// Closing bank on its own, no command needed
			if (auto_pend && cyc == auto_t) begin
				o_bank_open[auto_bank] <= 1'b0;
				close_t[auto_bank] <= cyc;
				auto_pend <= 1'b0;
			end
			if (!i_cs_n && i_ca_rise[1:0] == 2'b00) begin
				if (o_bank_open[bank] || cyc - close_t[bank] < RP_CYC) o_violations <= o_violations + 1;
				o_bank_open[bank] <= 1'b1;
				act_t[bank] <= cyc;
			end else if (!i_cs_n && i_ca_rise[1:0] == 2'b01) begin
				// Auto-close burst may not be cut; its bank stays barred until closed
				if (!o_bank_open[bank] || (acc_auto && gap < BL / 2) || (auto_pend && bank == auto_bank))
					o_violations <= o_violations + 1;
				acc_t <= cyc;
				acc_wr <= !i_ca_rise[2];
				acc_auto <= i_ca_fall[0];
				o_data_end <= cyc + (i_ca_rise[2] ? RL : WL) + BL / 2;
				acc_bank <= bank;
				{stop_used, live} <= 2'b01;
				bl_eff <= BL;
				if (i_ca_fall[0]) begin
					auto_pend <= 1'b1;
					auto_bank <= bank;
					auto_t <= cyc + (i_ca_rise[2] ? ((BL / 2 > BL / 2 - 2 + RTP_CYC) ? BL / 2 : BL / 2 - 2 + RTP_CYC)
						: WL + BL / 2 + 1 + WR_CYC);
				end
			end else if (!i_cs_n && i_ca_rise[3:0] == 4'b0011) begin
				if (!live || acc_auto || stop_used || gap[0] || gap > BL / 2 - 1) o_violations <= o_violations + 1;
				{stop_used, live} <= 2'b10;
				bl_eff <= 2 * gap;
				o_data_end <= cyc + (acc_wr ? WL : RL);
			end else if (!i_cs_n && i_ca_rise[3:0] == 4'b1011) begin
				for (int i = 0; i < 4; i++) begin
					if (i_ca_rise[4] || bank == i) begin
						if (o_bank_open[i] && cyc - act_t[i] < RAS_CYC) o_violations <= o_violations + 1;
						if (i == acc_bank && gap < (acc_wr ? wr_min : rd_min)) o_violations <= o_violations + 1;
						o_bank_open[i] <= 1'b0;
						close_t[i] <= cyc;
					end
				end
			end
		end
	end
endmodule : sbsp_mem_model

// [sbsp_ctrl_bench.sv]
// Self-checking bench for the burst-stop / precharge controller.
// Assumes one 100 MHz clock and the memory model on the command pins.
module sbsp_ctrl_bench
	import sbsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
	// ****************************************
	// Signals, instances, monitor
	// ****************************************
	logic        i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
	logic [3:0]  i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0000_0000, o_rdata, rv;
	logic        o_cs_n;
	logic [9:0]  o_ca_rise, o_ca_fall, last_ca, last_fall;
	logic [1:0]  o_write_byte_mask;
	logic [3:0]  m_open;
	int          mismatches = 0, check_count = 0, cyc = 0, n_iss = 0, last_t = 0, prev_t = 0, viol, d_end;
	sbsp_ctrl #(.BYTES(2)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .o_cs_n(o_cs_n), .o_ca_rise(o_ca_rise), .o_ca_fall(o_ca_fall),
		.o_write_byte_mask(o_write_byte_mask));
	sbsp_mem_model #(.BL(8), .WL(1), .RL(3)) model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(o_cs_n),
		.i_ca_rise(o_ca_rise), .i_ca_fall(o_ca_fall), .o_violations(viol), .o_data_end(d_end), .o_bank_open(m_open));
	initial forever #5 i_clk = ~i_clk;
	task test_done;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (!o_cs_n) begin
			n_iss <= n_iss + 1;
			prev_t <= last_t;
			last_t <= cyc;
			last_ca <= o_ca_rise;
			last_fall <= o_ca_fall;
		end
		// Hang guard, far above the hundred or so cycles needed
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end
	// ****************************************
	// Bus tasks
	// ****************************************
	task bus(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask : bus
	task rd(input logic [3:0] a, output logic [31:0] v);
		bus(1'b0, 1'b1, a, 32'h0000_0000);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		@(posedge i_clk);
	endtask : rd
	// Second op rides in the cycle the first one issues
	task issue(input sbsp_op_t op, input logic ap, input logic [1:0] bank, input sbsp_op_t op2);
		int t;
		t = n_iss + ((op2 == SBSP_OP_NONE) ? 1 : 2);
		bus(1'b1, 1'b0, REG_ADDR, {30'h0, bank});
		bus(1'b1, 1'b0, REG_CMD, {27'h0, ap, 1'b0, op});
		if (op2 != SBSP_OP_NONE) bus(1'b1, 1'b0, REG_CMD, {29'h0, op2});
		i_wr <= 1'b0;
		repeat (100) if (n_iss < t) @(posedge i_clk);
		`CHK("issued", 1'b1, n_iss >= t)
	endtask : issue
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(REG_CFG, rv);
		`CHK("cfg", CFG_RESET, rv)
		`CHK("cs idle", 1'b1, o_cs_n)
		`CHK("ca idle", 10'h3FF, o_ca_rise)
		$display("test reset done");
		issue(SBSP_OP_ACT, 1'b0, 2'd1, SBSP_OP_NONE);
		rd(REG_STATUS, rv);
		`CHK("open", 4'b0010, rv[5:2])
		issue(SBSP_OP_READ, 1'b0, 2'd1, SBSP_OP_NONE);
		`CHK("read code", 4'h5, last_ca[3:0])
		`CHK("read ap", 1'b0, last_fall[0])
		issue(SBSP_OP_READ, 1'b0, 2'd1, SBSP_OP_STOP);
		`CHK("stop code", 4'h3, last_ca[3:0])
		`CHK("stop gap", 2, last_t - prev_t)
		`CHK("read end", last_t + 3, d_end)
		issue(SBSP_OP_PRE, 1'b0, 2'd1, SBSP_OP_NONE);
		`CHK("pre code", 4'hB, last_ca[3:0])
		`CHK("pre bank", 3'b010, last_ca[8:6])
		rd(REG_STATUS, rv);
		`CHK("closed", 4'b0000, rv[5:2])
		$display("test read stop precharge done");
		bus(1'b1, 1'b0, REG_MASK, 32'h0000_0001);
		i_wr <= 1'b0;
		// Register lands on one edge, the pin on the next
		repeat (2) @(posedge i_clk);
		`CHK("mask", 2'b01, o_write_byte_mask)
		issue(SBSP_OP_ACT, 1'b0, 2'd2, SBSP_OP_NONE);
		issue(SBSP_OP_WRITE, 1'b1, 2'd2, SBSP_OP_NONE);
		`CHK("write code", 4'h1, last_ca[3:0])
		`CHK("write ap", 1'b1, last_fall[0])
		issue(SBSP_OP_ACT, 1'b0, 2'd2, SBSP_OP_NONE);
		`CHK("reopen gap", 1'b1, last_t - prev_t >= 1 + 4 + 1 + WR_CYC + RP_CYC)
		$display("test auto close write done");
		issue(SBSP_OP_ACT, 1'b0, 2'd3, SBSP_OP_NONE);
		issue(SBSP_OP_WRITE, 1'b0, 2'd3, SBSP_OP_STOP);
		`CHK("wstop gap", 2, last_t - prev_t)
		`CHK("write end", last_t + 1, d_end)
		rd(REG_STATUS, rv);
		`CHK("two open", 4'b1100, rv[5:2])
		issue(SBSP_OP_PREAB, 1'b0, 2'd0, SBSP_OP_NONE);
		`CHK("all flag", 5'b11011, last_ca[4:0])
		rd(REG_STATUS, rv);
		`CHK("all closed", 4'b0000, rv[5:2])
		`CHK("model closed", 4'b0000, m_open)
		`CHK("violations", 0, viol)
		$display("test all bank close done");
		test_done();
	end
endmodule : sbsp_ctrl_bench
